//--- nvic_pkg.sv
package nvic_pkg;
   localparam int NVIC_NUM_IRQ = 32;
   localparam int NVIC_PRIO_W = 8;
   localparam int NVIC_PRIO_PER_REG = 4;
   localparam int NVIC_NUM_PRIO_REG = 8;
   localparam int NVIC_PRIO_USED_MSB = 7;
   localparam int NVIC_PRIO_USED_LSB = 6;
   localparam int NVIC_ID_W = 5;
   localparam int NVIC_VEC_W = 6;
   localparam logic [5:0] NVIC_IRQ_VEC_BASE = 6'h10;
   localparam logic [31:0] NVIC_VTOR_BASE = 32'h0000_0000;
   localparam logic [31:0] NVIC_WORD_BYTES = 32'h0000_0004;
   localparam logic [31:0] NVIC_RST_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {
      NVIC_ST_IDLE = 2'b00,
      NVIC_ST_FETCH = 2'b01,
      NVIC_ST_SERVE = 2'b10
   } nvic_state_t;
endpackage

//--- nvic_arbiter.sv
`timescale 1ns/1ps
module nvic_arbiter
   import nvic_pkg::*;
#(
   parameter int NUM_IRQ = NVIC_NUM_IRQ
) (
   input wire logic [NUM_IRQ-1:0] cand_i,
   input wire logic [NUM_IRQ*2-1:0] level_i,
   output logic found_o,
   output logic [NVIC_ID_W-1:0] id_o,
   output logic [1:0] level_o
);
   // Lowest level wins; strict less-than keeps the lowest number on ties
   always_comb begin
      found_o = 1'b0;
      id_o = '0;
      level_o = 2'b11;
      for (int i = 0; i < NUM_IRQ; i++) begin
         if (cand_i[i] && (!found_o || level_i[i*2 +: 2] < level_o)) begin
            found_o = 1'b1;
            id_o = NVIC_ID_W'(i);
            level_o = level_i[i*2 +: 2];
         end
      end
   end
endmodule // nvic_arbiter

//--- nvic_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// RULE1: Writing one to set-enable bit enables that interrupt; zeros leave it.
// RULE2: Writing one to clear-enable bit disables that interrupt; zeros leave it.
// RULE3: Both enable registers read back current enable state.
// RULE4: Disabled interrupt request still becomes pending but never activates.
// RULE5: Active interrupt stays active when disabled until reset or return.
// RULE6: Cleared enable bit blocks any new activation.
// RULE7: Set-pending ones pend, clear-pending ones unpend; zeros do nothing.
// RULE8: Both pending registers read back current pending state.
// RULE9: Clear-pending write never changes active state.
// RULE10: Eight-bit priority field per interrupt, four per 32-bit register.
// RULE11: Vector entry zero holds the initial main stack pointer.
// RULE12: Other vector entries hold handler addresses by vector number.
// RULE13: All enable, pending, priority registers sit in one mapped block.
// RULE14: Thirty-two inputs, each with one of four priority levels.
// RULE15: Each input selectable as level or pulse sensitive.
// RULE16: Vector table base fixed at address zero.
// RULE17: On acceptance the handler address is fetched from the table.
// RULE18: Activation clears pending and sets active.
// RULE19: Most urgent pending enabled wins, lowest number breaks ties.
module nvic_ctrl
   import nvic_pkg::*;
#(
   parameter int NUM_IRQ = NVIC_NUM_IRQ
) (
   input wire logic CLOCK_I,
   input wire logic SYS_RST_I,
   input wire logic CLK_EN_I,
   input wire logic [NUM_IRQ-1:0] IRQ_I,
   input wire logic [NUM_IRQ-1:0] IRQ_PULSE_MODE_I,
   input wire logic [NUM_IRQ-1:0] SET_ENABLE_I,
   input wire logic [NUM_IRQ-1:0] CLR_ENABLE_I,
   input wire logic [NUM_IRQ-1:0] SET_PEND_I,
   input wire logic [NUM_IRQ-1:0] CLR_PEND_I,
   input wire logic PRIO_WR_I,
   input wire logic [2:0] PRIO_IDX_I,
   input wire logic [31:0] PRIO_WDATA_I,
   input wire logic [2:0] PRIO_RIDX_I,
   input wire logic ACCEPT_I,
   input wire logic EXC_RETURN_I,
   input wire logic [31:0] VEC_RDATA_I,
   input wire logic VEC_RVALID_I,
   output logic [NUM_IRQ-1:0] ENABLE_O,
   output logic [NUM_IRQ-1:0] PENDING_O,
   output logic [NUM_IRQ-1:0] ACTIVE_O,
   output logic [31:0] PRIO_RDATA_O,
   output logic IRQ_REQ_O,
   output logic [NVIC_ID_W-1:0] IRQ_ID_O,
   output logic VEC_RD_O,
   output logic [31:0] VEC_ADDR_O,
   output logic HANDLER_VALID_O,
   output logic [31:0] HANDLER_ADDR_O,
   output logic SP_VALID_O,
   output logic [31:0] INITIAL_MAIN_STACK_POINTER_O
);
   logic [NUM_IRQ-1:0] enable_q, pending_q, active_q, irq_prev_q;
   logic [NUM_IRQ-1:0] enable_d, pending_d, active_d;
   logic [NUM_IRQ*2-1:0] level_q;
   logic [NVIC_ID_W-1:0] serve_id_q;
   logic boot_q;
   nvic_state_t state_q, state_d;
   logic [31:0] prio_rd_w;
   logic [NUM_IRQ-1:0] req_event_w, cand_w, take_w;
   logic found_w;
   logic [NVIC_ID_W-1:0] win_id_w;
   logic [1:0] win_lvl_w;

   function automatic logic [31:0] vec_addr(input logic [5:0] vec);
      vec_addr = NVIC_VTOR_BASE + {26'h000_0000, vec} * NVIC_WORD_BYTES; // RULE16
   endfunction

   // Level lines pend while high, pulse lines on the rising edge
   assign req_event_w = (IRQ_I & ~IRQ_PULSE_MODE_I) | (IRQ_I & ~irq_prev_q & IRQ_PULSE_MODE_I); // RULE15
   // No new activation from a disabled or already active line
   assign cand_w = pending_q & enable_q & ~active_q; // RULE6
   // Nothing is taken while the boot read of the stack seed owns the vector port
   assign take_w = (state_q == NVIC_ST_IDLE && found_w && ACCEPT_I && !boot_q) ? (NUM_IRQ'(1) << win_id_w) : '0;

   nvic_arbiter #(.NUM_IRQ(NUM_IRQ)) u_arb (
      .cand_i(cand_w),
      .level_i(level_q),
      .found_o(found_w),
      .id_o(win_id_w),
      .level_o(win_lvl_w)
   ); // RULE19

   assign enable_d = (enable_q | SET_ENABLE_I) & ~CLR_ENABLE_I; // RULE1 RULE2
   // Hardware set wins over a software clear in the same cycle
   assign pending_d = ((pending_q & ~CLR_PEND_I) | SET_PEND_I | req_event_w) & ~take_w; // RULE4 RULE7 RULE18
   // Only returns clear active; enables and pend clears never touch it
   assign active_d = (active_q | take_w)
                     & ~((EXC_RETURN_I && state_q == NVIC_ST_SERVE) ? (NUM_IRQ'(1) << serve_id_q) : '0); // RULE5 RULE9

   // Only the top two bits of each byte are kept: four levels
   always_comb begin
      prio_rd_w = '0;
      for (int k = 0; k < NVIC_PRIO_PER_REG; k++) begin
         prio_rd_w[k*NVIC_PRIO_W + NVIC_PRIO_USED_LSB +: 2] = level_q[(PRIO_RIDX_I*4 + k)*2 +: 2]; // RULE10
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         NVIC_ST_IDLE: begin
            if (|take_w) begin
               state_d = NVIC_ST_FETCH;
            end
         end
         NVIC_ST_FETCH: begin
            if (VEC_RVALID_I) begin
               state_d = NVIC_ST_SERVE;
            end
         end
         NVIC_ST_SERVE: begin
            if (EXC_RETURN_I) begin
               state_d = NVIC_ST_IDLE;
            end
         end
         default: state_d = NVIC_ST_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         enable_q <= '0;
         pending_q <= '0;
         active_q <= '0;
         irq_prev_q <= '0;
         level_q <= '0;
         state_q <= NVIC_ST_IDLE;
         serve_id_q <= '0;
         boot_q <= 1'b1;
      end else if (CLK_EN_I) begin
         enable_q <= enable_d;
         pending_q <= pending_d;
         active_q <= active_d;
         irq_prev_q <= IRQ_I;
         state_q <= state_d;
         if (|take_w) begin
            serve_id_q <= win_id_w;
         end
         if (boot_q && VEC_RVALID_I) begin
            boot_q <= 1'b0;
         end
         if (PRIO_WR_I) begin
            for (int k = 0; k < NVIC_PRIO_PER_REG; k++) begin
               level_q[(PRIO_IDX_I*4 + k)*2 +: 2] <=
                  PRIO_WDATA_I[k*NVIC_PRIO_W + NVIC_PRIO_USED_LSB +: 2]; // RULE10 RULE13 RULE14
            end
         end
      end
   end

   // Registered outputs
   always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         ENABLE_O <= '0;
         PENDING_O <= '0;
         ACTIVE_O <= '0;
         PRIO_RDATA_O <= NVIC_RST_ZERO;
         IRQ_REQ_O <= 1'b0;
         IRQ_ID_O <= '0;
         VEC_RD_O <= 1'b0;
         VEC_ADDR_O <= NVIC_VTOR_BASE;
         HANDLER_VALID_O <= 1'b0;
         HANDLER_ADDR_O <= NVIC_RST_ZERO;
         SP_VALID_O <= 1'b0;
         INITIAL_MAIN_STACK_POINTER_O <= NVIC_RST_ZERO;
      end else if (CLK_EN_I) begin
         ENABLE_O <= enable_d; // RULE3
         PENDING_O <= pending_d; // RULE8
         ACTIVE_O <= active_d;
         PRIO_RDATA_O <= prio_rd_w;
         IRQ_REQ_O <= found_w && state_q == NVIC_ST_IDLE && !boot_q;
         IRQ_ID_O <= win_id_w;
         HANDLER_VALID_O <= 1'b0;
         SP_VALID_O <= 1'b0;
         if (boot_q) begin
            VEC_RD_O <= !VEC_RVALID_I;
            VEC_ADDR_O <= vec_addr(6'h00); // RULE11
            if (VEC_RVALID_I) begin
               SP_VALID_O <= 1'b1;
               INITIAL_MAIN_STACK_POINTER_O <= VEC_RDATA_I; // RULE11
            end
         end else if (|take_w) begin
            VEC_RD_O <= 1'b1;
            VEC_ADDR_O <= vec_addr(NVIC_IRQ_VEC_BASE + {1'b0, win_id_w}); // RULE12 RULE17
         end else if (state_q == NVIC_ST_FETCH && VEC_RVALID_I) begin
            VEC_RD_O <= 1'b0;
            HANDLER_VALID_O <= 1'b1;
            HANDLER_ADDR_O <= VEC_RDATA_I; // RULE17
         end
      end
   end

   property p_disabled_no_take;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
         CLK_EN_I && !enable_q[win_id_w] |-> !take_w[win_id_w];
   endproperty
   a_disabled_no_take: assert property (p_disabled_no_take) else $error("disabled line activated"); // RULE6

   property p_take_clears_pend;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
         CLK_EN_I && |take_w |=> active_q[$past(win_id_w)] && !pending_q[$past(win_id_w)]
            && state_q == NVIC_ST_FETCH && VEC_RD_O;
   endproperty
   a_take_clears_pend: assert property (p_take_clears_pend) else $error("activation not recorded"); // RULE18

   property p_clrpend_keeps_active;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
         CLK_EN_I && !EXC_RETURN_I |=> (active_q & $past(active_q)) == $past(active_q);
   endproperty
   a_clrpend_keeps_active: assert property (p_clrpend_keeps_active) else $error("active lost"); // RULE9

   property p_set_enable;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
         CLK_EN_I && SET_ENABLE_I[0] && !CLR_ENABLE_I[0] |=> enable_q[0] && ENABLE_O[0];
   endproperty
   a_set_enable: assert property (p_set_enable) else $error("enable not set"); // RULE1

   property p_clear_enable;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
         CLK_EN_I && CLR_ENABLE_I[0] |=> !enable_q[0] && !ENABLE_O[0];
   endproperty
   a_clear_enable: assert property (p_clear_enable) else $error("enable not cleared"); // RULE2

   property p_disabled_pends;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
         CLK_EN_I |=> (pending_q & $past(req_event_w & ~take_w)) == $past(req_event_w & ~take_w);
   endproperty
   a_disabled_pends: assert property (p_disabled_pends) else $error("request not pended"); // RULE4

   property p_return_clears;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
         CLK_EN_I && EXC_RETURN_I && state_q == NVIC_ST_SERVE |=> !active_q[$past(serve_id_q)]
            && state_q == NVIC_ST_IDLE;
   endproperty
   a_return_clears: assert property (p_return_clears) else $error("return left line active"); // RULE5

   // Reply to a handler read, then the handler address is presented
   sequence s_vec_reply;
      CLK_EN_I && state_q == NVIC_ST_FETCH && VEC_RVALID_I;
   endsequence

   property p_handler_fetch;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
         s_vec_reply |=> HANDLER_VALID_O && !VEC_RD_O && HANDLER_ADDR_O == $past(VEC_RDATA_I)
            && state_q == NVIC_ST_SERVE;
   endproperty
   a_handler_fetch: assert property (p_handler_fetch) else $error("handler address not given"); // RULE17
endmodule // nvic_ctrl

//--- nvic_mem_model.sv
`timescale 1ns/1ps
module nvic_mem_model #(
   parameter logic [31:0] SP_VAL = 32'h2000_0400
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] lat_i,
   input wire logic rd_i,
   input wire logic [31:0] addr_i,
   output logic [31:0] rdata_o,
   output logic rvalid_o
);
   logic [3:0] cnt_q;
   logic done_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 4'h0;
         done_q <= 1'b0;
         rvalid_o <= 1'b0;
         rdata_o <= 32'h0000_0000;
      end else begin
         rvalid_o <= 1'b0;
         // Idle bus toggles so a stale word never passes for a reply
         rdata_o <= ~rdata_o;
         if (!rd_i) begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
         end else if (!done_q && cnt_q >= lat_i) begin
            rvalid_o <= 1'b1;
            done_q <= 1'b1;
            rdata_o <= (addr_i == 32'h0000_0000) ? SP_VAL : (32'h0001_0000 | addr_i);
         end else if (!done_q) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule // nvic_mem_model

//--- nested_vectored_irq_ctrl_bench.sv
`timescale 1ns/1ps
module nested_vectored_irq_ctrl_bench;
   localparam logic [31:0] SP_VAL = 32'h2000_0400;
   logic clk = 1'b0, rst = 1'b1, en = 1'b1, pwr = 1'b0, acc = 1'b0, eret = 1'b0;
   logic [31:0] irq = 32'h0000_0000, pmode = 32'hFFFF_FF7F, pdat = 32'h0000_0000;
   logic [31:0] stb [4] = '{default: 32'h0000_0000};
   logic [2:0] pidx = 3'h0, ridx = 3'h0;
   logic [3:0] lat = 4'h0;
   logic [31:0] vdat, ena, pnd, act, prd, vaddr, haddr, sp;
   logic vval, vrd, hval, spv, irq_req;
   logic [4:0] irq_id;
   wire [2:0] evt = {spv, hval, vrd};
   int error_cnt = 0, n_compared = 0;
   int order [4] = '{2, 5, 6, 4};
   always #20 clk = ~clk;
   nvic_ctrl uut (.CLOCK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(en), .IRQ_I(irq), .IRQ_PULSE_MODE_I(pmode),
      .SET_ENABLE_I(stb[0]), .CLR_ENABLE_I(stb[1]), .SET_PEND_I(stb[2]), .CLR_PEND_I(stb[3]), .PRIO_WR_I(pwr),
      .PRIO_IDX_I(pidx), .PRIO_WDATA_I(pdat), .PRIO_RIDX_I(ridx), .ACCEPT_I(acc), .EXC_RETURN_I(eret),
      .VEC_RDATA_I(vdat), .VEC_RVALID_I(vval), .ENABLE_O(ena), .PENDING_O(pnd), .ACTIVE_O(act),
      .PRIO_RDATA_O(prd), .IRQ_REQ_O(irq_req), .IRQ_ID_O(irq_id), .VEC_RD_O(vrd), .VEC_ADDR_O(vaddr),
      .HANDLER_VALID_O(hval), .HANDLER_ADDR_O(haddr), .SP_VALID_O(spv), .INITIAL_MAIN_STACK_POINTER_O(sp));
   nvic_mem_model #(.SP_VAL(SP_VAL)) mem (.clk_i(clk), .rst_i(rst), .lat_i(lat), .rd_i(vrd),
      .addr_i(vaddr), .rdata_o(vdat), .rvalid_o(vval));
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic wt(input int s);
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         #1;
         if (evt[s] === 1'b1) return;
      end
      error_cnt++;
      $display("[FAIL] %0t timeout %0d", $time, s);
      end_sim;
   endtask
   // Strobe is sampled on one edge, output lands on that same edge
   task automatic wr(input int k, input logic [31:0] v);
      @(posedge clk);
      stb[k] <= v;
      @(posedge clk);
      stb[k] <= 32'h0000_0000;
      @(posedge clk);
      #1;
   endtask
   task automatic pread(input logic [2:0] i, input logic [31:0] e);
      @(posedge clk);
      ridx <= i;
      repeat (2) @(posedge clk);
      #1;
      chk(prd, e, "prio read");
   endtask
   task automatic serve(input int n);
      logic [31:0] b;
      b = 32'h0000_0001 << n;
      chk(32'(irq_req), 32'h0000_0001, "request");
      chk(32'(irq_id), 32'(n), "request id");
      @(posedge clk);
      acc <= 1'b1;
      lat <= 4'(n);
      wt(0);
      chk(act, b, "winner");
      chk(pnd & b, 32'h0000_0000, "pend kept");
      chk(vaddr, 32'h0000_0040 + (32'(n) << 2), "vec addr");
      @(posedge clk);
      acc <= 1'b0;
      wt(1);
      chk(haddr, 32'h0001_0040 + (32'(n) << 2), "handler");
      wr(1, b);
      wr(3, b);
      chk(act, b, "active lost");
      @(posedge clk);
      eret <= 1'b1;
      @(posedge clk);
      eret <= 1'b0;
      @(posedge clk);
      #1;
      chk(act, 32'h0000_0000, "return");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(ena | pnd | act, 32'h0000_0000, "reset");
      wt(0);
      chk(vaddr, 32'h0000_0000, "boot addr");
      wt(2);
      chk(sp, SP_VAL, "stack seed");
      wr(0, 32'hF0F0_00FF);
      chk(ena, 32'hF0F0_00FF, "set en");
      wr(0, 32'h0000_0000);
      chk(ena, 32'hF0F0_00FF, "set zero");
      wr(1, 32'h0000_000F);
      chk(ena, 32'hF0F0_00F0, "clr en");
      wr(1, 32'h0000_0000);
      chk(ena, 32'hF0F0_00F0, "clr zero");
      @(posedge clk);
      en <= 1'b0;
      wr(1, 32'hFFFF_FFFF);
      chk(ena, 32'hF0F0_00F0, "frozen");
      @(posedge clk);
      en <= 1'b1;
      wr(1, 32'hFFFF_FFFF);
      chk(ena, 32'h0000_0000, "clr all");
      wr(2, 32'h8000_0101);
      chk(pnd, 32'h8000_0101, "set pend");
      wr(3, 32'h8000_0001);
      chk(pnd, 32'h0000_0100, "clr pend");
      wr(3, 32'h0000_0000);
      chk(pnd, 32'h0000_0100, "clr zero");
      wr(3, 32'h0000_0100);
      @(posedge clk);
      irq <= 32'h0000_0020;
      acc <= 1'b1;
      @(posedge clk);
      irq <= 32'h0000_0000;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         #1;
         chk(32'(vrd | act[5] | irq_req), 32'h0000_0000, "disabled taken");
      end
      chk(pnd, 32'h0000_0020, "pulse pend");
      @(posedge clk);
      acc <= 1'b0;
      pidx <= 3'h1;
      pdat <= 32'hFF7F_3FC0;
      pwr <= 1'b1;
      @(posedge clk);
      pwr <= 1'b0;
      pread(3'h1, 32'hC040_00C0);
      pread(3'h0, 32'h0000_0000);
      wr(2, 32'h0000_0074);
      wr(0, 32'h0000_0074);
      for (int i = 0; i < 4; i++) serve(order[i]);
      @(posedge clk);
      irq <= 32'h0000_0180;
      wr(3, 32'h0000_0180);
      chk(pnd, 32'h0000_0080, "level line");
      @(posedge clk);
      irq <= 32'h0000_0000;
      wr(3, 32'h0000_0080);
      chk(pnd, 32'h0000_0000, "line low");
      end_sim;
   end
endmodule // nested_vectored_irq_ctrl_bench
